// file: bench/input_clock_switch_holdover_regs_tb_top.sv
// self-checking bench for the clock switch and holdover registers
`timescale 1ns/100ps
module input_clock_switch_holdover_regs_tb_top
  import clksel_pkg::*;
;
  // ******************************
  // signals and design
  // ******************************
  logic MCLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA;
  logic HREADYOUT;
  logic HRESP;
  logic [3:0] SIGNAL_ABSENT_ALARM = 4'h0;
  logic [3:0] FREQ_OFFSET_ALARM = 4'h0;
  logic [1:0] INPUT_SELECT_PIN = 2'h0;
  logic HISTORY_SUFFICIENT = 1'b0;
  logic FAST_LOCK_ACTIVE = 1'b0;
  logic [1:0] SELECTED_INPUT;
  logic HOLDOVER;
  logic PHASE_BUILDOUT_ON;
  logic [3:0] HITLESS_VARIANT;
  logic [9:0] PHASE_MEASURE_THRESHOLD;
  logic [4:0] COARSE_MEASURE_LENGTH;
  logic [4:0] COARSE_MEASURE_DELAY;
  logic [3:0] FINE_MEASURE_LENGTH;
  logic [12:0] DETECTOR_ENABLE_DELAY;
  logic [7:0] DYNAMIC_CHANGE_RESERVED;
  logic IRQ;
  int fails = 0;
  int tests_run = 0;
  logic [7:0] wv [NUM_RW];
  logic [11:0] rk;
  logic [7:0] msk;
  logic [3:0] abs_a;
  logic [3:0] off_a;
  logic [2:0] best;

  always #10 MCLK = ~MCLK;

  input_clock_switch_holdover_regs uut (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .SIGNAL_ABSENT_ALARM(SIGNAL_ABSENT_ALARM),
    .FREQ_OFFSET_ALARM(FREQ_OFFSET_ALARM),
    .INPUT_SELECT_PIN(INPUT_SELECT_PIN),
    .HISTORY_SUFFICIENT(HISTORY_SUFFICIENT),
    .FAST_LOCK_ACTIVE(FAST_LOCK_ACTIVE), .SELECTED_INPUT(SELECTED_INPUT),
    .HOLDOVER(HOLDOVER), .PHASE_BUILDOUT_ON(PHASE_BUILDOUT_ON),
    .HITLESS_VARIANT(HITLESS_VARIANT),
    .PHASE_MEASURE_THRESHOLD(PHASE_MEASURE_THRESHOLD),
    .COARSE_MEASURE_LENGTH(COARSE_MEASURE_LENGTH),
    .COARSE_MEASURE_DELAY(COARSE_MEASURE_DELAY),
    .FINE_MEASURE_LENGTH(FINE_MEASURE_LENGTH),
    .DETECTOR_ENABLE_DELAY(DETECTOR_ENABLE_DELAY),
    .DYNAMIC_CHANGE_RESERVED(DYNAMIC_CHANGE_RESERVED), .IRQ(IRQ)
  );

  // ******************************
  // tasks and expectations
  // ******************************
  task automatic close_out;
    if (fails == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wait_ready(output logic [31:0] d);
    @(posedge MCLK);
    while (HREADYOUT !== 1'b1) begin
      @(posedge MCLK);
    end
    d = HRDATA;
  endtask : wait_ready

  task automatic bus(input logic w, input logic [IDX_W-1:0] idx,
                     input logic [7:0] wd, output logic [7:0] rdat);
    logic [31:0] d;
    @(posedge MCLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {19'h0, idx, 2'h0};
    wait_ready(d);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= {24'h0, wd};
    wait_ready(d);
    rdat = d[7:0];
  endtask : bus

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] v);
    logic [7:0] x;
    bus(1'b1, idx, v, x);
  endtask : wr

  task automatic rdchk(input logic [IDX_W-1:0] idx, input logic [7:0] e);
    logic [7:0] x;
    bus(1'b0, idx, 8'h00, x);
    chk({24'h0, x}, {24'h0, e}, "register read");
  endtask : rdchk

  task automatic look(input int n);
    repeat (n) @(posedge MCLK);
    @(negedge MCLK);
  endtask : look

  task automatic do_reset;
    @(posedge MCLK);
    SYS_RST <= 1'b1;
    repeat (4) @(posedge MCLK);
    SYS_RST <= 1'b0;
  endtask : do_reset

  task automatic setup_sel(input logic [11:0] r, input logic [7:0] m,
                           input logic [3:0] a, input logic [3:0] o);
    wr(REG_IDX[S_RANK01], {1'b0, r[5:3], 1'b0, r[2:0]});
    wr(REG_IDX[S_RANK23], {1'b0, r[11:9], 1'b0, r[8:6]});
    wr(REG_IDX[S_MASKS], m);
    SIGNAL_ABSENT_ALARM <= a;
    FREQ_OFFSET_ALARM <= o;
  endtask : setup_sel

  function automatic logic [3:0] avail(input logic [7:0] m,
                                       input logic [3:0] a,
                                       input logic [3:0] o);
    return ~(a & ~m[3:0]) & ~(o & ~m[7:4]);
  endfunction : avail

  function automatic logic [2:0] pick(input logic [11:0] r,
                                      input logic [3:0] av);
    logic [2:0] b;
    logic [2:0] br;
    b = 3'h0;
    br = 3'h7;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      if (av[i] && r[i*3+:3] != 3'h0 && r[i*3+:3] <= 3'h4 &&
          r[i*3+:3] < br) begin
        br = r[i*3+:3];
        b = {1'b1, 2'(i)};
      end
    end
    return b;
  endfunction : pick

  // ******************************
  // tests
  // ******************************
  initial begin
    repeat (20000) @(posedge MCLK);
    fails++;
    close_out;
  end

  initial begin
    void'($urandom(54));
    do_reset;
    for (int i = 0; i < NUM_RW; i++) begin
      rdchk(REG_IDX[i], REG_RST[i]);
    end
    rdchk(IDX_STATUS, 8'h00);
    wr(11'h541, 8'hFF);
    rdchk(11'h541, 8'h00);
    for (int i = 0; i < NUM_RW; i++) begin
      wv[i] = 8'($urandom);
      if (i == S_VARIANT) wv[i] = 8'h01;
      if (i == S_DYN || i == S_IRQ_MASK) wv[i] = 8'h00;
      if (i == S_SWITCH && wv[i][1:0] == 2'h3) begin
        wv[i][1:0] = 2'h2;
      end
      wr(REG_IDX[i], wv[i]);
    end
    for (int i = 0; i < NUM_RW; i++) begin
      rdchk(REG_IDX[i], wv[i] & REG_WMASK[i]);
    end
    look(1);
    chk(PHASE_MEASURE_THRESHOLD,
        {wv[S_THR_HI][1:0], wv[S_THR_LO]}, "thr");
    chk(DETECTOR_ENABLE_DELAY, {wv[S_DET_HI][4:0], wv[S_DET_LO]}, "det");
    chk(COARSE_MEASURE_DELAY, wv[S_CDLY][4:0], "coarse delay");
    chk(COARSE_MEASURE_LENGTH, wv[S_CLEN][4:0], "coarse length");
    chk(FINE_MEASURE_LENGTH, wv[S_FLEN][3:0], "fine length");
    chk(DYNAMIC_CHANGE_RESERVED, 8'h00, "reserved byte");
    chk(HRESP, 32'h0, "okay");
    chk(HITLESS_VARIANT, 32'h1, "variant");
    do_reset;
    rdchk(REG_IDX[S_THR_LO], 8'h00);
    wr(REG_IDX[S_SWITCH], 8'h04);
    look(3);
    chk(PHASE_BUILDOUT_ON, 32'h1, "buildout on");
    wr(IDX_ZERO_DELAY, 8'h01);
    look(3);
    chk(PHASE_BUILDOUT_ON, 32'h0, "buildout zdm");
    wr(IDX_ZERO_DELAY, 8'h00);
    wr(REG_IDX[S_SWITCH], 8'h00);
    look(3);
    chk(PHASE_BUILDOUT_ON, 32'h0, "buildout off");
    chk(HOLDOVER, 32'h0, "normal");
    wr(REG_IDX[S_FORCE], 8'h01);
    look(3);
    chk(HOLDOVER, 32'h1, "forced");
    rdchk(IDX_IRQ_STATUS, 8'h01);
    wr(REG_IDX[S_FORCE], 8'h00);
    look(3);
    chk(HOLDOVER, 32'h0, "unforced");
    for (int i = 0; i < NUM_INPUTS; i++) begin
      wr(IDX_INPUT_SELECT, {5'h0, 2'(i), 1'b1});
      look(3);
      chk(SELECTED_INPUT, i, "manual reg");
    end
    wr(IDX_ZERO_DELAY, 8'h01);
    wr(IDX_INPUT_SELECT, 8'h01);
    look(3);
    chk(SELECTED_INPUT, 32'h3, "zdm hold");
    wr(IDX_ZERO_DELAY, 8'h00);
    wr(IDX_INPUT_SELECT, 8'h00);
    INPUT_SELECT_PIN <= 2'h2;
    FREQ_OFFSET_ALARM <= 4'h4;
    look(7);
    chk(SELECTED_INPUT, 32'h2, "manual pin");
    chk(HOLDOVER, 32'h1, "manual alarm");
    wr(REG_IDX[S_MASKS], 8'h40);
    look(3);
    chk(HOLDOVER, 32'h0, "alarm masked");
    setup_sel(12'h00A, 8'h00, 4'h2, 4'h0);
    wr(REG_IDX[S_SWITCH], 8'h01);
    look(3);
    chk(SELECTED_INPUT, 32'h0, "fallback");
    rdchk(IDX_IRQ_STATUS, 8'h03);
    @(posedge MCLK);
    SIGNAL_ABSENT_ALARM <= 4'h0;
    look(3);
    chk(SELECTED_INPUT, 32'h0, "non-revertive");
    wr(REG_IDX[S_SWITCH], 8'h02);
    look(3);
    chk(SELECTED_INPUT, 32'h1, "revertive");
    for (int n = 0; n < 30; n++) begin
      for (int j = 0; j < NUM_INPUTS; j++) begin
        rk[j*3+:3] = 3'($urandom_range(4));
      end
      msk = 8'($urandom);
      abs_a = 4'($urandom);
      off_a = 4'($urandom);
      if (n < 2) begin
        rk = (n == 0) ? 12'h249 : 12'h6DB;
        abs_a = 4'(n);
        off_a = 4'h0;
      end
      setup_sel(rk, msk, abs_a, off_a);
      best = pick(rk, avail(msk, abs_a, off_a));
      look(3);
      if (best[2]) begin
        chk(SELECTED_INPUT, best[1:0], "auto");
      end
      chk(HOLDOVER, !best[2], "auto hold");
    end
    wr(IDX_IRQ_STATUS, 8'h0F);
    wr(IDX_IRQ_MASK, 8'h08);
    look(2);
    chk(IRQ, 32'h0, "irq idle");
    @(posedge MCLK);
    FAST_LOCK_ACTIVE <= 1'b1;
    HISTORY_SUFFICIENT <= 1'b1;
    look(3);
    chk(IRQ, 32'h1, "irq raised");
    rdchk(IDX_STATUS, 8'h06);
    rdchk(IDX_IRQ_STATUS, 8'h0C);
    wr(IDX_IRQ_MASK, 8'h00);
    look(1);
    chk(IRQ, 32'h0, "irq masked");
    wr(IDX_IRQ_MASK, 8'h08);
    wr(IDX_IRQ_STATUS, 8'h08);
    look(1);
    chk(IRQ, 32'h0, "irq cleared");
    rdchk(IDX_IRQ_STATUS, 8'h04);
    close_out;
  end
endmodule : input_clock_switch_holdover_regs_tb_top

// file: hdl/input_clock_switch_holdover_regs.sv
// input clock selection, holdover control and its register bank
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/100ps
// Function
// - force bit set puts device in holdover
// - mode field: manual, non-revertive, revertive, reserved
// - buildout bit picks glitchless or hitless switching
// - zero delay mode disables hitless switching
// - signal-absent mask removes alarm from selection
// - frequency-offset mask removes alarm from selection
// - automatic mode picks lowest ranked available input
// - equal ranks prefer input 0,1,2,3
// - selection result can force holdover entry
// - ten-bit threshold split over two registers
// - status bit 1 shows holdover history sufficient
// - status bit 2 shows fast-lock operation
// - two-bit select field picks manual input when bit 0 is set (else the pin does), unless zero delay mode is on
module input_clock_switch_holdover_regs
  import clksel_pkg::*;
(
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [NUM_INPUTS-1:0] SIGNAL_ABSENT_ALARM,
  input wire logic [NUM_INPUTS-1:0] FREQ_OFFSET_ALARM,
  input wire logic [SEL_W-1:0] INPUT_SELECT_PIN,
  input wire logic HISTORY_SUFFICIENT,
  input wire logic FAST_LOCK_ACTIVE,
  output logic [SEL_W-1:0] SELECTED_INPUT,
  output logic HOLDOVER,
  output logic PHASE_BUILDOUT_ON,
  output logic [VARIANT_W-1:0] HITLESS_VARIANT,
  output logic [9:0] PHASE_MEASURE_THRESHOLD,
  output logic [CLEN_W-1:0] COARSE_MEASURE_LENGTH,
  output logic [CLEN_W-1:0] COARSE_MEASURE_DELAY,
  output logic [FLEN_W-1:0] FINE_MEASURE_LENGTH,
  output logic [12:0] DETECTOR_ENABLE_DELAY,
  output logic [BYTE_W-1:0] DYNAMIC_CHANGE_RESERVED,
  output logic IRQ
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [BYTE_W-1:0] cfg [NUM_RW];
  logic [IDX_W-1:0] idx_q;
  logic hit_q;
  logic wr_pend;
  logic rd_pend;
  logic [BYTE_W-1:0] rdata_q;
  logic [BYTE_W-1:0] rd_mux;
  logic accept;
  logic [NUM_EV-1:0] irq_stat;
  logic [NUM_EV-1:0] irq_clr;
  logic [NUM_EV-1:0] events;
  logic hist_q;
  logic fast_q;
  logic [SEL_W-1:0] pin_s1;
  logic [SEL_W-1:0] pin_s2;
  logic [SEL_W-1:0] pin_s3;
  logic [SEL_W-1:0] pin_sel;
  logic [SEL_W-1:0] sel;
  logic [SEL_W-1:0] next_sel;
  logic [SEL_W-1:0] manual_target;
  logic hold;
  logic next_hold;
  logic buildout;
  logic [NUM_INPUTS-1:0] clean;
  logic [NUM_INPUTS-1:0] avail;
  logic [NUM_INPUTS*RANK_W-1:0] ranks;
  logic best_ok;
  logic [SEL_W-1:0] best_idx;
  switch_mode_t mode;
  logic force_hold;
  logic zdm;
  logic regctrl;

  // ****************************************************************
  // bus slave
  // ****************************************************************
  assign accept = HSEL && HTRANS[TRANS_ACTIVE_BIT] && HREADY;
  assign HREADYOUT = !rd_pend;
  assign HRESP = 1'b0;
  assign HRDATA = 32'(rdata_q);

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      idx_q <= '0;
      hit_q <= 1'b0;
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
    end else begin
      if (accept) begin
        idx_q <= HADDR[IDX_W+1:2];
        hit_q <= HADDR[31:IDX_W+2] == '0;
      end
      wr_pend <= accept && HWRITE;
      rd_pend <= accept && !HWRITE;
    end
  end

  // read data captured during the wait cycle, after any prior write
  always_comb begin
    rd_mux = '0;
    for (int k = 0; k < NUM_RW; k++) begin
      if (idx_q == REG_IDX[k]) begin
        rd_mux = cfg[k];
      end
    end
    if (idx_q == IDX_STATUS) begin
      rd_mux[HIST_BIT] = hist_q;
      rd_mux[FAST_BIT] = fast_q;
    end
    if (idx_q == IDX_IRQ_STATUS) begin
      rd_mux = BYTE_W'(irq_stat);
    end
    if (!hit_q) begin
      rd_mux = '0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      rdata_q <= '0;
    end else if (rd_pend) begin
      rdata_q <= rd_mux;
    end
  end

  // ****************************************************************
  // writable registers, one per slot
  // ****************************************************************
  generate
    for (genvar g = 0; g < NUM_RW; g++) begin : g_reg
      always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
          cfg[g] <= REG_RST[g];
        end else if (wr_pend && hit_q && idx_q == REG_IDX[g]) begin
          cfg[g] <= HWDATA[BYTE_W-1:0] & REG_WMASK[g];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // configuration fields
  // ****************************************************************
  assign force_hold = cfg[S_FORCE][FORCE_BIT];
  assign mode = switch_mode_t'(cfg[S_SWITCH][MODE_LO +: MODE_W]);
  assign zdm = cfg[S_ZDM][ZDM_BIT];
  assign regctrl = cfg[S_INSEL][REGCTRL_BIT];
  // software keeps the defaults; passed through
  assign HITLESS_VARIANT = cfg[S_VARIANT][VARIANT_W-1:0];
  assign PHASE_MEASURE_THRESHOLD =
    {cfg[S_THR_HI][THR_HI_W-1:0], cfg[S_THR_LO]};
  assign COARSE_MEASURE_LENGTH = cfg[S_CLEN][CLEN_W-1:0];
  assign COARSE_MEASURE_DELAY = cfg[S_CDLY][CLEN_W-1:0];
  assign FINE_MEASURE_LENGTH = cfg[S_FLEN][FLEN_W-1:0];
  assign DETECTOR_ENABLE_DELAY =
    {cfg[S_DET_HI][DET_HI_W-1:0], cfg[S_DET_LO]};
  assign DYNAMIC_CHANGE_RESERVED = cfg[S_DYN];

  // ****************************************************************
  // select pin synchroniser
  // ****************************************************************
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pin_sel <= '0;
    end else begin
      pin_s1 <= INPUT_SELECT_PIN;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3) begin
        pin_sel <= pin_s3;
      end
    end
  end

  // ****************************************************************
  // per-input eligibility
  // ****************************************************************
  generate
    for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_in
      localparam int SLOT = (i < 2) ? S_RANK01 : S_RANK23;
      localparam int LO = (i % 2 == 0) ? RANK_A_LO : RANK_B_LO;
      assign ranks[i*RANK_W +: RANK_W] = cfg[SLOT][LO +: RANK_W];
      assign clean[i] =
        !(SIGNAL_ABSENT_ALARM[i] &&
          !cfg[S_MASKS][ABSENT_MASK_LO + i]) &&
        !(FREQ_OFFSET_ALARM[i] &&
          !cfg[S_MASKS][OFFSET_MASK_LO + i]);
      assign avail[i] = clean[i] &&
        ranks[i*RANK_W +: RANK_W] != RANK_NONE &&
        ranks[i*RANK_W +: RANK_W] <= RANK_MAX;
    end
  endgenerate

  rank_picker #(
    .N(NUM_INPUTS),
    .RW(RANK_W),
    .IW(SEL_W)
  ) u_picker (
    .ranks(ranks),
    .avail(avail),
    .best_ok(best_ok),
    .best_idx(best_idx)
  );

  // ****************************************************************
  // selection and holdover
  // ****************************************************************
  always_comb begin
    // register select is inert under zero delay mode
    if (regctrl) begin
      manual_target = zdm ? sel : cfg[S_INSEL][INSEL_LO +: SEL_W];
    end else begin
      manual_target = pin_sel;
    end
    case (mode)
      MODE_MANUAL: begin
        next_sel = manual_target;
        next_hold = !clean[manual_target];
      end
      MODE_NONREVERT: begin
        next_sel = (avail[sel] || !best_ok) ? sel : best_idx;
        next_hold = !(avail[sel] || best_ok);
      end
      MODE_REVERT: begin
        next_sel = best_ok ? best_idx : sel;
        next_hold = !best_ok;
      end
      default: begin
        next_sel = sel;
        next_hold = !clean[sel];
      end
    endcase
    next_hold = next_hold || force_hold;
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      sel <= '0;
      hold <= 1'b0;
      buildout <= 1'b0;
    end else begin
      sel <= next_sel;
      hold <= next_hold;
      buildout <= cfg[S_SWITCH][BUILDOUT_BIT] && !zdm;
    end
  end

  assign SELECTED_INPUT = sel;
  assign HOLDOVER = hold;
  assign PHASE_BUILDOUT_ON = buildout;

  // ****************************************************************
  // status and interrupts
  // ****************************************************************
  assign events[EV_HOLD] = next_hold && !hold;
  assign events[EV_SWITCH] = next_sel != sel;
  assign events[EV_HIST] = HISTORY_SUFFICIENT && !hist_q;
  assign events[EV_FAST] = FAST_LOCK_ACTIVE && !fast_q;
  assign irq_clr = (wr_pend && hit_q && idx_q == IDX_IRQ_STATUS) ?
    HWDATA[NUM_EV-1:0] : '0;

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      hist_q <= 1'b0;
      fast_q <= 1'b0;
    end else begin
      hist_q <= HISTORY_SUFFICIENT;
      fast_q <= FAST_LOCK_ACTIVE;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | events;
    end
  end

  assign IRQ = |(irq_stat & cfg[S_IRQ_MASK][NUM_EV-1:0]);

  // ****************************************************************
  // assertions
  // ****************************************************************
  logic better_exists;

  always_comb begin
    better_exists = 1'b0;
    for (int j = 0; j < NUM_INPUTS; j++) begin
      if (avail[j] && best_ok &&
          (ranks[j*RANK_W +: RANK_W] <
           ranks[best_idx*RANK_W +: RANK_W])) begin
        better_exists = 1'b1;
      end
    end
  end

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SYS_RST);

  a_force_hold:
    assert property (force_hold |=> HOLDOVER)
    else $error("forced holdover not entered");

  a_revert_pick:
    assert property (mode == MODE_REVERT && best_ok
      |=> SELECTED_INPUT == $past(best_idx))
    else $error("revertive mode did not take best input");

  a_buildout_on:
    assert property (cfg[S_SWITCH][BUILDOUT_BIT] && !zdm
      |=> PHASE_BUILDOUT_ON)
    else $error("phase buildout not enabled");

  a_zero_delay:
    assert property (zdm |=> !PHASE_BUILDOUT_ON)
    else $error("buildout active in zero delay mode");

  a_absent_mask:
    assert property (best_ok |-> !(SIGNAL_ABSENT_ALARM[best_idx] &&
      !cfg[S_MASKS][ABSENT_MASK_LO + best_idx]))
    else $error("unmasked absent input chosen");

  a_offset_mask:
    assert property (best_ok |-> !(FREQ_OFFSET_ALARM[best_idx] &&
      !cfg[S_MASKS][OFFSET_MASK_LO + best_idx]))
    else $error("unmasked offset input chosen");

  a_rank_valid:
    assert property (best_ok |->
      ranks[best_idx*RANK_W +: RANK_W] inside {[3'h1:RANK_MAX]})
    else $error("input with invalid rank chosen");

  a_lowest_rank:
    assert property (!better_exists)
    else $error("lower ranked input was available");

  a_tie_order:
    assert property (best_ok && best_idx != '0 && avail[0] |->
      ranks[0 +: RANK_W] > ranks[best_idx*RANK_W +: RANK_W])
    else $error("tie not broken toward input zero");

  a_auto_hold:
    assert property (mode == MODE_REVERT && !best_ok |=> HOLDOVER)
    else $error("no available input yet not in holdover");

  a_status_read:
    assert property (rd_pend && hit_q && idx_q == IDX_STATUS
      |=> HRDATA[HIST_BIT] == $past(hist_q) && HREADYOUT)
    else $error("history flag read wrong");

  a_fast_read:
    assert property (rd_pend && hit_q && idx_q == IDX_STATUS
      |=> HRDATA[FAST_BIT] == $past(fast_q))
    else $error("fast lock flag read wrong");

  a_manual_reg:
    assert property (mode == MODE_MANUAL && regctrl && !zdm
      |=> SELECTED_INPUT == $past(cfg[S_INSEL][INSEL_LO +: SEL_W]))
    else $error("manual register select ignored");

  a_nonrev_keep:
    assert property (mode == MODE_NONREVERT && avail[sel]
      |=> $stable(SELECTED_INPUT))
    else $error("non-revertive mode left a valid input");

  a_read_wait:
    assert property (accept && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait state wrong");

  c_revert_switch: cover property (mode == MODE_REVERT &&
    events[EV_SWITCH]);
  c_hold_entry: cover property (events[EV_HOLD] && !force_hold);
  c_irq_raise: cover property (!IRQ ##1 IRQ);
  c_status_read: cover property (rd_pend && idx_q == IDX_STATUS);

endmodule : input_clock_switch_holdover_regs

// file: hdl/rank_picker.sv
// lowest-rank input picker with fixed index tie-break
`timescale 1ns/100ps
module rank_picker
  import clksel_pkg::*;
#(
  parameter int N = NUM_INPUTS,
  parameter int RW = RANK_W,
  parameter int IW = SEL_W
) (
  input wire logic [N*RW-1:0] ranks,
  input wire logic [N-1:0] avail,
  output logic best_ok,
  output logic [IW-1:0] best_idx
);

  logic [RW-1:0] best_rank;

  // ****************************************************************
  // scan from the top so the lower index wins a tie
  // ****************************************************************
  always_comb begin
    best_ok = 1'b0;
    best_idx = '0;
    best_rank = '1;
    for (int i = N - 1; i >= 0; i--) begin
      if (avail[i] && ranks[i*RW +: RW] <= best_rank) begin
        best_ok = 1'b1;
        best_idx = IW'(i);
        best_rank = ranks[i*RW +: RW];
      end
    end
  end

endmodule : rank_picker

// file: include/clksel_pkg.sv
// constants and types for the input clock switch and holdover registers
package clksel_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int NUM_INPUTS = 4;
  localparam int RANK_W = 3;
  localparam int SEL_W = 2;
  localparam int IDX_W = 11;
  localparam int BYTE_W = 8;
  localparam int NUM_RW = 17;
  localparam int NUM_EV = 4;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [IDX_W-1:0] IDX_ZERO_DELAY = 11'h487;
  localparam logic [IDX_W-1:0] IDX_INPUT_SELECT = 11'h52A;
  localparam logic [IDX_W-1:0] IDX_STATUS = 11'h53F;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 11'h5F0;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 11'h5F1;

  // writable slots in table order
  localparam int S_FORCE = 0;
  localparam int S_SWITCH = 1;
  localparam int S_MASKS = 2;
  localparam int S_RANK01 = 3;
  localparam int S_RANK23 = 4;
  localparam int S_VARIANT = 5;
  localparam int S_THR_LO = 6;
  localparam int S_THR_HI = 7;
  localparam int S_CLEN = 8;
  localparam int S_CDLY = 9;
  localparam int S_DYN = 10;
  localparam int S_FLEN = 11;
  localparam int S_DET_LO = 12;
  localparam int S_DET_HI = 13;
  localparam int S_INSEL = 14;
  localparam int S_ZDM = 15;
  localparam int S_IRQ_MASK = 16;

  localparam logic [IDX_W-1:0] REG_IDX [NUM_RW] = '{
    11'h535, 11'h536, 11'h537, 11'h538, 11'h539, 11'h53A, 11'h53B,
    11'h53C, 11'h53D, 11'h53E, 11'h540, 11'h588, 11'h589, 11'h58A,
    IDX_INPUT_SELECT, IDX_ZERO_DELAY, IDX_IRQ_MASK};
  localparam logic [BYTE_W-1:0] REG_WMASK [NUM_RW] = '{
    8'h01, 8'h07, 8'hFF, 8'h77, 8'h77, 8'h0F, 8'hFF,
    8'h03, 8'h1F, 8'h1F, 8'hFF, 8'h0F, 8'hFF, 8'h1F,
    8'h07, 8'h01, 8'h0F};
  localparam logic [BYTE_W-1:0] REG_RST [NUM_RW] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00};

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int FORCE_BIT = 0;
  localparam int MODE_LO = 0;
  localparam int MODE_W = 2;
  localparam int BUILDOUT_BIT = 2;
  localparam int ABSENT_MASK_LO = 0;
  localparam int OFFSET_MASK_LO = 4;
  localparam int RANK_A_LO = 0;
  localparam int RANK_B_LO = 4;
  localparam int HIST_BIT = 1;
  localparam int FAST_BIT = 2;
  localparam int REGCTRL_BIT = 0;
  localparam int INSEL_LO = 1;
  localparam int ZDM_BIT = 0;
  localparam int THR_HI_W = 2;
  localparam int CLEN_W = 5;
  localparam int FLEN_W = 4;
  localparam int DET_HI_W = 5;
  localparam int VARIANT_W = 4;

  localparam logic [RANK_W-1:0] RANK_NONE = 3'h0;
  localparam logic [RANK_W-1:0] RANK_MAX = 3'h4;

  // interrupt event bits
  localparam int EV_HOLD = 0;
  localparam int EV_SWITCH = 1;
  localparam int EV_HIST = 2;
  localparam int EV_FAST = 3;

  localparam int TRANS_ACTIVE_BIT = 1;

  typedef enum logic [1:0] {
    MODE_MANUAL,
    MODE_NONREVERT,
    MODE_REVERT,
    MODE_RESERVED
  } switch_mode_t;

endpackage : clksel_pkg
